// *** bus_area_cfg.svh ***
`ifndef BUS_AREA_CFG_SVH
`define BUS_AREA_CFG_SVH

// register byte addresses
`define CFG_ADDR_BUS_CONFIG   32'h0FFFFFE0
`define CFG_ADDR_BASIC_WAIT   32'h0FFFFFE4
`define CFG_ADDR_STATUS       32'h0FFFFFEC

// external_bus_config fields
`define CFG_ENDIAN_BIT        12
`define CFG_BURST_ROM_BIT     11
`define CFG_PARTIAL_BIT       10
`define CFG_LW23_HI           9
`define CFG_LW23_LO           8
`define CFG_LW1_HI            7
`define CFG_LW1_LO            6
`define CFG_LW0_HI            5
`define CFG_LW0_LO            4
`define CFG_MEMTYPE_HI        2
`define CFG_MEMTYPE_LO        0
`define CFG_WRITE_MASK        16'h1FF7
`define CFG_RESET_BUS_CONFIG  16'h0000
`define CFG_RESET_BASIC_WAIT  8'hFF

// memory type codes
`define CFG_MT_ORDINARY       3'h0
`define CFG_MT_A3_SDRAM       3'h1
`define CFG_MT_A3_DRAM        3'h2
`define CFG_MT_A3_PSRAM       3'h3
`define CFG_MT_A2_SDRAM       3'h4
`define CFG_MT_BOTH_SDRAM     3'h5
`define CFG_MT_RESERVED_HI    2'h3

// wait timing
`define CFG_LONG_WAIT_BASE    3'h3
`define CFG_BASIC_LONG_CODE   2'h3

// bus responses
`define CFG_RESP_OKAY         2'h0
`define CFG_RESP_SLVERR       2'h2

`endif

// *** bus_area_pkg.sv ***
package bus_area_pkg;

	typedef enum logic [1:0] {
		AREA_ORDINARY,
		AREA_SDRAM,
		AREA_DRAM,
		AREA_PSRAM
	} area_kind_e;

	typedef enum logic [1:0] {
		MASTER_TOTAL,
		MASTER_PARTIAL,
		MASTER_OTHER
	} master_mode_e;

endpackage

// *** cycle_if.sv ***
`timescale 1ns/1ns
interface cycle_if;
	import bus_area_pkg::*;
	logic        start;
	logic [1:0]  area;
	logic [15:0] config_word;
	logic [7:0]  basic_wait;
	logic [2:0]  waits;
	logic        ext_wait_enable;
	logic        little_endian;
	logic        burst_rom;
	area_kind_e  area_kind;

	modport cfg_side (
		output start, area, config_word, basic_wait,
		input  waits, ext_wait_enable, little_endian, burst_rom, area_kind
	);
	modport latch_side (
		input  start, area, config_word, basic_wait,
		output waits, ext_wait_enable, little_endian, burst_rom, area_kind
	);
endinterface

// *** cycle_settings_latch.sv ***
`timescale 1ns/1ns
`include "bus_area_cfg.svh"
module cycle_settings_latch
	import bus_area_pkg::*;
(
	// clock and reset
	input  wire logic   aclk,
	input  wire logic   aresetn,
	// request and settings
	cycle_if.latch_side c
);

	logic [1:0] basic_code;
	logic [1:0] long_code;
	logic [2:0] mem_type;

	always_comb begin
		basic_code = c.basic_wait[2*c.area +: 2];
		mem_type   = c.config_word[`CFG_MEMTYPE_HI:`CFG_MEMTYPE_LO];
		if (c.area == 2'h0) begin
			long_code = c.config_word[`CFG_LW0_HI:`CFG_LW0_LO];
		end else if (c.area == 2'h1) begin
			long_code = c.config_word[`CFG_LW1_HI:`CFG_LW1_LO];
		end else begin
			long_code = c.config_word[`CFG_LW23_HI:`CFG_LW23_LO];
		end
	end

	// long wait when basic code is 11
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c.waits           <= 3'h0;
			c.ext_wait_enable <= 1'b0;
		end else if (c.start) begin
			c.ext_wait_enable <= (basic_code != 2'h0);
			if (basic_code == `CFG_BASIC_LONG_CODE) begin
				c.waits <= `CFG_LONG_WAIT_BASE + {1'b0, long_code};
			end else begin
				c.waits <= {1'b0, basic_code};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c.little_endian <= 1'b0;
			c.burst_rom     <= 1'b0;
		end else if (c.start) begin
			c.little_endian <= (c.area == 2'h2) &&
				c.config_word[`CFG_ENDIAN_BIT];
			c.burst_rom     <= (c.area == 2'h0) &&
				c.config_word[`CFG_BURST_ROM_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c.area_kind <= AREA_ORDINARY;
		end else if (c.start) begin
			c.area_kind <= AREA_ORDINARY;
			if (c.area == 2'h2) begin
				if (mem_type == `CFG_MT_A2_SDRAM ||
					mem_type == `CFG_MT_BOTH_SDRAM) begin
					c.area_kind <= AREA_SDRAM;
				end
			end else if (c.area == 2'h3) begin
				if (mem_type == `CFG_MT_A3_SDRAM ||
					mem_type == `CFG_MT_BOTH_SDRAM) begin
					c.area_kind <= AREA_SDRAM;
				end else if (mem_type == `CFG_MT_A3_DRAM) begin
					c.area_kind <= AREA_DRAM;
				end else if (mem_type == `CFG_MT_A3_PSRAM) begin
					c.area_kind <= AREA_PSRAM;
				end
			end
		end
	end

	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_LONG_WAIT: assert property (
		c.start && basic_code == 2'h3 |=>
		c.waits == 3'h3 + {1'b0, $past(long_code)} && c.ext_wait_enable)
		else $error("long wait count wrong");
	AST_BASIC_WAIT: assert property (
		c.start && basic_code != 2'h3 |=>
		c.waits == {1'b0, $past(basic_code)} &&
		c.ext_wait_enable == ($past(basic_code) != 2'h0))
		else $error("basic wait decode wrong");
	AST_ENDIAN: assert property (
		c.start && c.area == 2'h2 |=>
		c.little_endian == $past(c.config_word[`CFG_ENDIAN_BIT]))
		else $error("area 2 byte order wrong");
	AST_BURST: assert property (
		c.start |=> c.burst_rom ==
		($past(c.area) == 2'h0 && $past(c.config_word[`CFG_BURST_ROM_BIT])))
		else $error("burst rom select wrong");
	AST_AREA3_KIND: assert property (
		c.start && c.area == 2'h3 && mem_type == 3'h2 |=>
		c.area_kind == AREA_DRAM)
		else $error("area 3 kind wrong");
	AST_AREA2_KIND: assert property (
		c.start && c.area == 2'h2 |=> c.area_kind ==
		(($past(mem_type) == 3'h4 || $past(mem_type) == 3'h5) ?
		AREA_SDRAM : AREA_ORDINARY))
		else $error("area 2 kind wrong");
	AST_HOLD: assert property (
		!c.start |=> $stable(c.waits) && $stable(c.area_kind) &&
		$stable(c.little_endian))
		else $error("settings changed mid cycle");
	AST_RESET_KIND: assert property (
		c.start && mem_type == 3'h0 |=> c.area_kind == AREA_ORDINARY)
		else $error("ordinary space not kept");

	COV_LONG: cover property (c.start && basic_code == 2'h3 ##1 c.waits == 3'h6);
	COV_SDRAM: cover property (c.start ##1 c.area_kind == AREA_SDRAM);
	COV_LITTLE: cover property (c.start ##1 c.little_endian);

endmodule

// *** external_bus_area_config.sv ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "bus_area_cfg.svh"
// Notes on behaviour
// - bit 12 set gives area 2 little-endian
// - bit 11 set gives area 0 burst ROM
// - mode pin low: bit 10 picks partial-share
// - long-wait codes give three to six waits
// - memory type field, reset ordinary
// - codes 1-3 make area 3 SDRAM/DRAM/PSRAM
// - codes 4,5 SDRAM area 2; 6,7 forbidden
// - basic code 11 uses long wait, ext wait
module external_bus_area_config
	import bus_area_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	// axi4-lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// mode strap pin
	input  wire logic        mode_pin_five,
	// bus cycle generator
	input  wire logic        cycle_start,
	input  wire logic [1:0]  cycle_area,
	input  wire logic        cycle_done,
	output logic [2:0]       cycle_waits,
	output logic             cycle_ext_wait_enable,
	output logic             cycle_little_endian,
	output logic             cycle_burst_rom,
	output area_kind_e       cycle_area_kind,
	output master_mode_e     master_mode
);

	logic [15:0] external_bus_config;
	logic [7:0]  area_basic_wait_control;
	logic        mode_meta;
	logic        mode_sync;
	logic        cycle_active;
	logic        aw_held;
	logic        w_held;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic        write_fire;
	logic        next_aw_held;
	logic        next_w_held;
	logic        next_bvalid;
	logic        next_rvalid;
	logic [15:0] merged;
	logic [15:0] next_config;

	cycle_if cyc ();

	// two flops: the pin is asynchronous to aclk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_meta <= 1'b0;
			mode_sync <= 1'b0;
		end else begin
			mode_meta <= mode_pin_five;
			mode_sync <= mode_meta;
		end
	end

	// master mode from pin and bit 10
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			master_mode <= MASTER_TOTAL;
		end else if (mode_sync) begin
			master_mode <= MASTER_OTHER;
		end else if (external_bus_config[`CFG_PARTIAL_BIT]) begin
			master_mode <= MASTER_PARTIAL;
		end else begin
			master_mode <= MASTER_TOTAL;
		end
	end

	// start wins over done in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cycle_active <= 1'b0;
		end else if (cycle_start) begin
			cycle_active <= 1'b1;
		end else if (cycle_done) begin
			cycle_active <= 1'b0;
		end
	end

	always_comb begin
		aw_hs        = awvalid && awready;
		w_hs         = wvalid && wready;
		ar_hs        = arvalid && arready;
		write_fire   = aw_held && w_held && !bvalid;
		next_aw_held = (aw_held || aw_hs) && !write_fire;
		next_w_held  = (w_held || w_hs) && !write_fire;
		next_bvalid  = write_fire || (bvalid && !bready);
		next_rvalid  = ar_hs || (rvalid && !rready);
		merged[15:8] = w_strb_q[1] ? w_data_q[15:8] :
			external_bus_config[15:8];
		merged[7:0]  = w_strb_q[0] ? w_data_q[7:0] :
			external_bus_config[7:0];
		next_config  = merged & `CFG_WRITE_MASK;
		// forbidden codes leave the field as it was
		if (merged[2:1] == `CFG_MT_RESERVED_HI) begin
			next_config[2:0] = external_bus_config[2:0];
		end
	end

	// address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			aw_addr_q <= 32'h00000000;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			awready <= !next_aw_held && !next_bvalid;
			wready  <= !next_w_held && !next_bvalid;
			if (aw_hs) begin
				aw_addr_q <= awaddr;
			end
			if (w_hs) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `CFG_RESP_OKAY;
		end else begin
			bvalid <= next_bvalid;
			if (write_fire) begin
				if (aw_addr_q == `CFG_ADDR_BUS_CONFIG ||
					aw_addr_q == `CFG_ADDR_BASIC_WAIT ||
					aw_addr_q == `CFG_ADDR_STATUS) begin
					bresp <= `CFG_RESP_OKAY;
				end else begin
					bresp <= `CFG_RESP_SLVERR;
				end
			end
		end
	end

	// reset gives ordinary spaces, three waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			external_bus_config     <= `CFG_RESET_BUS_CONFIG;
			area_basic_wait_control <= `CFG_RESET_BASIC_WAIT;
		end else if (write_fire) begin
			if (aw_addr_q == `CFG_ADDR_BUS_CONFIG) begin
				external_bus_config <= next_config;
			end else if (aw_addr_q == `CFG_ADDR_BASIC_WAIT && w_strb_q[0]) begin
				area_basic_wait_control <= w_data_q[7:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `CFG_RESP_OKAY;
		end else begin
			rvalid  <= next_rvalid;
			arready <= !next_rvalid;
			if (ar_hs) begin
				rresp <= `CFG_RESP_OKAY;
				if (araddr == `CFG_ADDR_BUS_CONFIG) begin
					rdata <= {16'h0000, external_bus_config};
				end else if (araddr == `CFG_ADDR_BASIC_WAIT) begin
					rdata <= {24'h000000, area_basic_wait_control};
				end else if (araddr == `CFG_ADDR_STATUS) begin
					rdata <= {28'h0000000, cycle_active, master_mode,
						mode_sync};
				end else begin
					rdata <= 32'h00000000;
					rresp <= `CFG_RESP_SLVERR;
				end
			end
		end
	end

	// settings sampled only at cycle start
	assign cyc.start       = cycle_start;
	assign cyc.area        = cycle_area;
	assign cyc.config_word = external_bus_config;
	assign cyc.basic_wait  = area_basic_wait_control;

	cycle_settings_latch u_latch (
		.aclk    (aclk),
		.aresetn (aresetn),
		.c       (cyc.latch_side)
	);

	assign cycle_waits           = cyc.waits;
	assign cycle_ext_wait_enable = cyc.ext_wait_enable;
	assign cycle_little_endian   = cyc.little_endian;
	assign cycle_burst_rom       = cyc.burst_rom;
	assign cycle_area_kind       = cyc.area_kind;

	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_NO_RESERVED: assert property (
		external_bus_config[2:1] != 2'h3)
		else $error("forbidden memory type stored");
	AST_MODE: assert property (
		##2 !mode_sync && !$past(mode_sync) |=> master_mode ==
		($past(external_bus_config[10]) ? MASTER_PARTIAL : MASTER_TOTAL))
		else $error("master mode wrong");
	AST_WRITE_RESP: assert property (
		write_fire |=> bvalid && !awready && !wready)
		else $error("write response missing");
	AST_READ_RESP: assert property (
		ar_hs |=> rvalid && !arready)
		else $error("read response missing");

	COV_WRITE_CFG: cover property (write_fire &&
		aw_addr_q == `CFG_ADDR_BUS_CONFIG);
	COV_PARTIAL: cover property (master_mode == MASTER_PARTIAL);

endmodule

// *** cycle_gen_model.sv ***
`timescale 1ns/1ns
module cycle_gen_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// bench request
	input  wire logic       req,
	input  wire logic [1:0] req_area,
	output logic            busy,
	// config block side
	input  wire logic [2:0] cycle_waits,
	output logic            cycle_start,
	output logic [1:0]      cycle_area,
	output logic            cycle_done
);
	logic [3:0] cnt;
	logic       arm;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy        <= 1'b0;
			cycle_start <= 1'b0;
			cycle_done  <= 1'b0;
			cycle_area  <= 2'h0;
			cnt         <= 4'h0;
			arm         <= 1'b0;
		end else begin
			cycle_start <= req && !busy;
			cycle_done  <= 1'b0;
			arm         <= cycle_start;
			// area means nothing outside start, so keep it moving
			cycle_area  <= (req && !busy) ? req_area : ~cycle_area;
			if (req && !busy)
				busy <= 1'b1;
			// waits settle one edge after start, so load them then
			else if (arm)
				cnt <= {1'b0, cycle_waits} + 4'h1;
			else if (busy && !cycle_start && cnt <= 4'h1) begin
				busy       <= 1'b0;
				cycle_done <= 1'b1;
			end else if (busy)
				cnt <= cnt - 4'h1;
		end
	end
endmodule

// *** tb_external_bus_area_config.sv ***
`timescale 1ns/1ns
`include "bus_area_cfg.svh"
module tb_external_bus_area_config;
	import bus_area_pkg::*;
	localparam logic [31:0] addr_cfg = `CFG_ADDR_BUS_CONFIG;
	localparam logic [31:0] addr_bw  = `CFG_ADDR_BASIC_WAIT;
	logic         aclk, aresetn, awvalid, awready, wvalid, wready;
	logic         bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0]  awaddr, wdata, araddr, rdata;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp, req_area, cycle_area;
	logic         mode_pin_five, req, busy, cycle_start, cycle_done, sd;
	logic [2:0]   cycle_waits;
	logic         cycle_ext_wait_enable, cycle_little_endian;
	logic         cycle_burst_rom;
	area_kind_e   cycle_area_kind;
	master_mode_e master_mode;
	logic [15:0]  mcfg;
	logic [3:0]   mstat;
	logic [7:0]   mbw, outv;
	logic [33:0]  rq[$];
	logic [1:0]   bq[$];
	logic [7:0]   cq[$];
	int           mismatches, n_tests;

	assign outv = {cycle_waits, cycle_ext_wait_enable, cycle_little_endian,
		cycle_burst_rom, cycle_area_kind};

	external_bus_area_config external_bus_area_config_inst (.aclk, .aresetn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .mode_pin_five, .cycle_start,
		.cycle_area, .cycle_done, .cycle_waits, .cycle_ext_wait_enable,
		.cycle_little_endian, .cycle_burst_rom, .cycle_area_kind,
		.master_mode);
	cycle_gen_model cycle_gen_model_inst (.aclk, .aresetn, .req, .req_area,
		.busy, .cycle_waits, .cycle_start, .cycle_area, .cycle_done);

	always #4 aclk = ~aclk;

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [7:0] exp_cyc(input logic [1:0] a);
		logic [1:0] b;
		logic [1:0] lw;
		logic [2:0] n;
		logic [1:0] k;
		b = mbw[2*a +: 2];
		lw = (a == 2'h0) ? mcfg[5:4] : (a == 2'h1) ? mcfg[7:6] : mcfg[9:8];
		n = (b == `CFG_BASIC_LONG_CODE) ? `CFG_LONG_WAIT_BASE + {1'b0, lw}
			: {1'b0, b};
		k = 2'h0;
		if (a == 2'h2 && mcfg[2])
			k = 2'h1;
		if (a == 2'h3 && mcfg[2:0] != 3'h4)
			k = (mcfg[2:0] == 3'h5) ? 2'h1 : mcfg[1:0];
		return {n, b != 2'h0, a == 2'h2 && mcfg[12], a == 2'h0 && mcfg[11], k};
	endfunction

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic pa, pw, pb;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		if (a == addr_cfg) begin
			// unstrobed lanes keep their old contents
			if (!wstrb[1])
				d[15:8] = mcfg[15:8];
			if (!wstrb[0])
				d[7:0] = mcfg[7:0];
			// prohibited memory types leave the old field in place
			if (d[2:1] == `CFG_MT_RESERVED_HI)
				d[2:0] = mcfg[2:0];
			mcfg = d[15:0] & `CFG_WRITE_MASK;
		end else if (a == addr_bw && wstrb[0])
			mbw = d[7:0];
		bq.push_back((a == addr_cfg || a == addr_bw || a == `CFG_ADDR_STATUS)
			? `CFG_RESP_OKAY : `CFG_RESP_SLVERR);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (pa || pw || pb) begin
			@(posedge aclk);
			if (pa && awready) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && wready) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (bvalid) begin
				bready <= 1'b0;
				pb = 1'b0;
			end
		end
		// idle edge: the next call must not re-raise bready in this step
		@(posedge aclk);
	endtask

	task automatic rd(input logic [31:0] a);
		logic p;
		p = 1'b1;
		if (a == addr_cfg)
			rq.push_back({`CFG_RESP_OKAY, 16'h0, mcfg});
		else if (a == addr_bw)
			rq.push_back({`CFG_RESP_OKAY, 24'h0, mbw});
		else if (a == `CFG_ADDR_STATUS)
			rq.push_back({`CFG_RESP_OKAY, 28'h0, mstat});
		else
			rq.push_back({`CFG_RESP_SLVERR, 32'h0});
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (p) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				p = 1'b0;
			end
		end
		// idle edge: the next call must not re-raise rready in this step
		@(posedge aclk);
	endtask

	task automatic cyc(input logic [1:0] a);
		while (busy)
			@(posedge aclk);
		cq.push_back(exp_cyc(a));
		req      <= 1'b1;
		req_area <= a;
		@(posedge aclk);
		req <= 1'b0;
		@(posedge aclk);
	endtask

	always @(posedge aclk) begin
		sd <= cycle_start && aresetn;
		if (rvalid && rready)
			check({rresp, rdata}, rq.pop_front());
		if (bvalid && bready)
			check({32'h0, bresp}, {32'h0, bq.pop_front()});
		if (sd)
			check({26'h0, outv}, {26'h0, cq.pop_front()});
	end

	initial begin
		#400000;
		mismatches++;
		print_verdict;
	end

	initial begin
		aclk = 0; aresetn = 0; awaddr = 0; wdata = 0; wstrb = 4'hF;
		awvalid = 0; wvalid = 0; bready = 0; araddr = 0; arvalid = 0;
		rready = 0; mode_pin_five = 0; req = 0; req_area = 0; sd = 0;
		mismatches = 0;
		n_tests = 0;
		mcfg = `CFG_RESET_BUS_CONFIG;
		mbw = `CFG_RESET_BASIC_WAIT;
		void'($urandom(32'h34cb8332));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(addr_cfg);
		rd(addr_bw);
		rd(32'h0FFFFFF0);
		wr(32'h0FFFFFF0, 32'hFFFF);
		for (int a = 0; a < 4; a++)
			cyc(a[1:0]);
		$display("test reset and unmapped done");
		for (int i = 0; i < 8; i++) begin
			wr(addr_cfg, i);
			cyc(2'h2);
			cyc(2'h3);
			rd(addr_cfg);
		end
		$display("test memory types done");
		for (int i = 0; i < 4; i++) begin
			wr(addr_cfg, {22'h0, i[1:0], i[1:0], i[1:0], 4'h0});
			for (int a = 0; a < 4; a++)
				cyc(a[1:0]);
		end
		$display("test long waits done");
		for (int i = 0; i < 12; i++) begin
			wr(addr_cfg, $urandom & 32'hFFFF);
			wr(addr_bw, $urandom & 32'hFF);
			for (int a = 0; a < 4; a++)
				cyc(a[1:0]);
			rd(addr_cfg);
			rd(addr_bw);
		end
		$display("test random settings done");
		wr(addr_bw, 32'hFF);
		wr(addr_cfg, 32'h1300);
		cyc(2'h2);
		wr(addr_cfg, 32'h0);
		check(outv, {3'h6, 1'b1, 1'b1, 1'b0, 2'h0});
		cyc(2'h2);
		$display("test mid-cycle write done");
		wstrb <= 4'h2;
		@(posedge aclk);
		wr(addr_cfg, 32'hFFFF);
		wr(addr_bw, 32'h0);
		wstrb <= 4'hF;
		rd(addr_cfg);
		rd(addr_bw);
		$display("test byte strobes done");
		for (int i = 0; i < 4; i++) begin
			mode_pin_five <= i[1];
			wr(addr_cfg, {21'h0, i[0], 10'h0});
			repeat (4) @(posedge aclk);
			check({32'h0, master_mode}, {32'h0, i[1] ? MASTER_OTHER
				: i[0] ? MASTER_PARTIAL : MASTER_TOTAL});
		end
		$display("test master mode done");
		while (busy)
			@(posedge aclk);
		repeat (3) @(posedge aclk);
		// idle, pin high: other mode, synced pin set
		mstat = {1'b0, MASTER_OTHER, 1'b1};
		rd(`CFG_ADDR_STATUS);
		$display("test status done");
		print_verdict;
	end
endmodule
